// [shared/pce_pkg.sv]
// constants and carrier types for the control and enable register bank
// assumes an 8-bit register port driven by the serial interface engine
package pce_pkg;

  // register subaddresses
  localparam logic [7:0] PCE_ADDR_POWER_CONTROL   = 8'h06;
  localparam logic [7:0] PCE_ADDR_RETENTION_FLAGS = 8'h07;
  localparam logic [7:0] PCE_ADDR_UNLOCK_KEY      = 8'h10;
  localparam logic [7:0] PCE_ADDR_CONV_ENABLES    = 8'h11;
  localparam logic [7:0] PCE_ADDR_SWITCH_ENABLES  = 8'h12;

  // reset values and the unlock key readback value
  localparam logic [7:0] PCE_RST_POWER_CONTROL   = 8'h00;
  localparam logic [7:0] PCE_RST_RETENTION_FLAGS = 8'h00;
  localparam logic [7:0] PCE_RST_CONV_ENABLES    = 8'h00;
  localparam logic [7:0] PCE_RST_SWITCH_ENABLES  = 8'h00;
  localparam logic [7:0] PCE_UNLOCK_READBACK     = 8'h00;

  // power_control fields
  localparam int PCE_BIT_MEASURE_TRIGGER = 0;
  localparam int PCE_BIT_PFAIL_SHUTDOWN  = 1;
  localparam logic [7:0] PCE_MASK_POWER_CONTROL = 8'h03;

  // converter_enables fields
  localparam int PCE_BIT_CONV1 = 0;
  localparam int PCE_BIT_CONV2 = 1;
  localparam int PCE_BIT_CONV3 = 2;
  localparam int PCE_BIT_CONV4 = 3;
  localparam int PCE_BIT_CONV5 = 4;
  localparam int PCE_BIT_CONV6 = 5;
  localparam logic [7:0] PCE_MASK_CONV_ENABLES = 8'h3f;

  // switch_output_enables fields
  localparam int PCE_BIT_LINREG  = 0;
  localparam int PCE_BIT_SWITCH1 = 1;
  localparam int PCE_BIT_SWITCH2 = 2;
  localparam int PCE_BIT_SWITCH3 = 3;
  localparam int PCE_BIT_OUT1    = 4;
  localparam int PCE_BIT_OUT2    = 5;
  localparam int PCE_BIT_OUT3    = 6;
  localparam logic [7:0] PCE_MASK_SWITCH_ENABLES = 8'h7f;

  // retention flag positions, bit 0 up to bit 7
  localparam int PCE_FLG_CONV1  = 0;
  localparam int PCE_FLG_CONV2  = 1;
  localparam int PCE_FLG_CONV3  = 2;
  localparam int PCE_FLG_CONV4  = 3;
  localparam int PCE_FLG_LINREG = 4;
  localparam int PCE_FLG_OUT1   = 5;
  localparam int PCE_FLG_OUT2   = 6;
  localparam int PCE_FLG_OUT3   = 7;

  // unlock key default, arbitrary value
  localparam logic [7:0] PCE_UNLOCK_KEY_DEFAULT = 8'h5a;

  // register access from the serial engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pce_req_t;

  // values loaded by the power sequencer
  typedef struct packed {
    logic load;
    logic conv1_on;
    logic conv2_on;
    logic conv3_on;
    logic conv4_on;
    logic backup_conv5_on;
    logic switch1_on;
    logic linreg_on;
  } pce_seq_t;

  // all rail enables seen by the analog side
  typedef struct packed {
    logic backup_conv6_on;
    logic backup_conv5_on;
    logic conv4_on;
    logic conv3_on;
    logic conv2_on;
    logic conv1_on;
    logic switch3_on;
    logic switch2_on;
    logic switch1_on;
    logic linreg_on;
  } pce_rails_t;

endpackage

// [hw/pce_regs.sv]
// control, retention-flag, unlock-key and enable registers of the power manager
// assumes the serial engine presents single-cycle read and write strobes on core_clk
`timescale 1ns/1ps
`default_nettype none

module pce_regs
  import pce_pkg::*;
#(
  parameter logic [7:0] UNLOCK_KEY = PCE_UNLOCK_KEY_DEFAULT
) (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rstn,
  // register port from the serial engine
  input  wire pce_req_t req,
  output logic [7:0]  rdata,
  output logic        rvalid,
  // power state machine
  input  wire pce_seq_t seq,
  input  wire logic   wake_from_suspend,
  input  wire logic   wake_from_off,
  input  wire logic   freshness_seal_state,
  input  wire logic   power_fail_comparator_out_n,
  output logic        power_fail_shutdown,
  output logic        backup_cell_measure_start,
  output pce_rails_t  rails,
  // pin configuration from the configuration registers
  input  wire logic   conv_warm_reset_pin_en,
  input  wire logic   io1_pair_sel,
  // general-purpose pins, open drain
  input  wire logic   out1_i,
  output logic        out1_o,
  output logic        out1_oe,
  output logic        out2_o,
  output logic        out2_oe,
  input  wire logic   out3_i,
  output logic        out3_o,
  output logic        out3_oe,
  output logic        conv_warm_reset_n
);

  typedef struct packed {
    logic [7:0] power_control;
    logic [7:0] retention_flags;
    logic [7:0] conv_enables;
    logic [7:0] switch_enables;
    logic       unlocked;
    logic       shutdown;
    logic       measure_start;
    logic [7:0] rdata;
    logic       rvalid;
  } pce_state_t;

  pce_state_t st;
  pce_state_t next_st;

  function automatic logic [7:0] read_mux(input pce_state_t s, input logic [7:0] a);
    case (a)
      PCE_ADDR_POWER_CONTROL:   read_mux = s.power_control & PCE_MASK_POWER_CONTROL;
      PCE_ADDR_RETENTION_FLAGS: read_mux = s.retention_flags;
      PCE_ADDR_UNLOCK_KEY:      read_mux = PCE_UNLOCK_READBACK;
      PCE_ADDR_CONV_ENABLES:    read_mux = s.conv_enables & PCE_MASK_CONV_ENABLES;
      PCE_ADDR_SWITCH_ENABLES:  read_mux = s.switch_enables & PCE_MASK_SWITCH_ENABLES;
      default:                  read_mux = 8'h00;
    endcase
  endfunction

  logic       protected_wr;
  logic [7:0] wd;
  logic       seal_fresh;

  always_comb begin
    next_st = st;
    wd = req.wdata;
    seal_fresh = ~freshness_seal_state;
    protected_wr = req.wr && (req.addr == PCE_ADDR_CONV_ENABLES || req.addr == PCE_ADDR_SWITCH_ENABLES);

    // trigger is a one-cycle request, cleared by hardware next cycle
    next_st.measure_start = 1'b0;
    next_st.power_control[PCE_BIT_MEASURE_TRIGGER] = 1'b0;

    next_st.rvalid = req.rd;
    if (req.rd) begin
      next_st.rdata = read_mux(st, req.addr);
    end

    if (req.wr) begin
      // any write other than a correct key closes the unlock window
      next_st.unlocked = 1'b0;
      case (req.addr)
        PCE_ADDR_POWER_CONTROL: begin
          next_st.power_control[PCE_BIT_PFAIL_SHUTDOWN] = wd[PCE_BIT_PFAIL_SHUTDOWN];
          if (wd[PCE_BIT_MEASURE_TRIGGER]) begin
            next_st.power_control[PCE_BIT_MEASURE_TRIGGER] = 1'b1;
            next_st.measure_start = 1'b1;
          end
        end
        PCE_ADDR_UNLOCK_KEY: begin
          next_st.unlocked = (wd == UNLOCK_KEY);
        end
        PCE_ADDR_CONV_ENABLES: begin
          if (st.unlocked) begin
            next_st.conv_enables = wd & PCE_MASK_CONV_ENABLES;
            // backup rails only drop while the seal is still fresh
            if (!seal_fresh) begin
              next_st.conv_enables[PCE_BIT_CONV6] = st.conv_enables[PCE_BIT_CONV6] | wd[PCE_BIT_CONV6];
              next_st.conv_enables[PCE_BIT_CONV5] = st.conv_enables[PCE_BIT_CONV5] | wd[PCE_BIT_CONV5];
            end
          end
        end
        PCE_ADDR_SWITCH_ENABLES: begin
          if (st.unlocked) begin
            next_st.switch_enables = wd & PCE_MASK_SWITCH_ENABLES;
          end
        end
        default: begin
        end
      endcase
      if (protected_wr && !st.unlocked) begin
        next_st.unlocked = 1'b0;
      end
    end

    // sequencer wins over a host write in the same cycle
    if (seq.load) begin
      next_st.conv_enables[PCE_BIT_CONV1] = seq.conv1_on;
      next_st.conv_enables[PCE_BIT_CONV2] = seq.conv2_on;
      next_st.conv_enables[PCE_BIT_CONV3] = seq.conv3_on;
      next_st.conv_enables[PCE_BIT_CONV4] = seq.conv4_on;
      next_st.switch_enables[PCE_BIT_SWITCH1] = seq.switch1_on;
      next_st.switch_enables[PCE_BIT_LINREG] = seq.linreg_on;
      // seal still guards the backup rail against the sequencer
      if (seal_fresh || seq.backup_conv5_on) begin
        next_st.conv_enables[PCE_BIT_CONV5] = seq.backup_conv5_on;
      end
    end

    // enabled state of conv1-conv4, linreg and out1-out3 is captured as the device leaves suspend
    if (wake_from_off) begin
      next_st.retention_flags = PCE_RST_RETENTION_FLAGS;
    end else if (wake_from_suspend) begin
      next_st.retention_flags[PCE_FLG_CONV1]  = st.conv_enables[PCE_BIT_CONV1];
      next_st.retention_flags[PCE_FLG_CONV2]  = st.conv_enables[PCE_BIT_CONV2];
      next_st.retention_flags[PCE_FLG_CONV3]  = st.conv_enables[PCE_BIT_CONV3];
      next_st.retention_flags[PCE_FLG_CONV4]  = st.conv_enables[PCE_BIT_CONV4];
      next_st.retention_flags[PCE_FLG_LINREG] = st.switch_enables[PCE_BIT_LINREG];
      next_st.retention_flags[PCE_FLG_OUT1]   = st.switch_enables[PCE_BIT_OUT1];
      next_st.retention_flags[PCE_FLG_OUT2]   = st.switch_enables[PCE_BIT_OUT2];
      next_st.retention_flags[PCE_FLG_OUT3]   = st.switch_enables[PCE_BIT_OUT3];
    end

    // power-fail trip overrides enable writes, sequencer loads and the unlock window this cycle
    next_st.shutdown = 1'b0;
    if (st.power_control[PCE_BIT_PFAIL_SHUTDOWN] && !power_fail_comparator_out_n) begin
      next_st.shutdown = 1'b1;
      next_st.conv_enables = PCE_RST_CONV_ENABLES;
      // pin levels are not rails, so they keep their stored value
      next_st.switch_enables = st.switch_enables;
      next_st.switch_enables[PCE_BIT_SWITCH3:PCE_BIT_LINREG] = 4'h0;
      next_st.unlocked = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st.power_control   <= PCE_RST_POWER_CONTROL;
      st.retention_flags <= PCE_RST_RETENTION_FLAGS;
      st.conv_enables    <= PCE_RST_CONV_ENABLES;
      st.switch_enables  <= PCE_RST_SWITCH_ENABLES;
      st.unlocked        <= 1'b0;
      st.shutdown        <= 1'b0;
      st.measure_start   <= 1'b0;
      st.rdata           <= 8'h00;
      st.rvalid          <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // register outputs
  assign rdata  = st.rdata;
  assign rvalid = st.rvalid;
  assign power_fail_shutdown       = st.shutdown;
  assign backup_cell_measure_start = st.measure_start;

  assign rails.backup_conv6_on = st.conv_enables[PCE_BIT_CONV6];
  assign rails.backup_conv5_on = st.conv_enables[PCE_BIT_CONV5];
  assign rails.conv4_on        = st.conv_enables[PCE_BIT_CONV4];
  assign rails.conv3_on        = st.conv_enables[PCE_BIT_CONV3];
  assign rails.conv2_on        = st.conv_enables[PCE_BIT_CONV2];
  assign rails.conv1_on        = st.conv_enables[PCE_BIT_CONV1];
  assign rails.switch3_on      = st.switch_enables[PCE_BIT_SWITCH3];
  assign rails.switch2_on      = st.switch_enables[PCE_BIT_SWITCH2];
  assign rails.switch1_on      = st.switch_enables[PCE_BIT_SWITCH1];
  assign rails.linreg_on       = st.switch_enables[PCE_BIT_LINREG];

  // open-drain pins only ever pull low
  assign out1_o = 1'b0;
  assign out2_o = 1'b0;
  assign out3_o = 1'b0;

  // paired mode: pin1 becomes an input and its level is copied onto out2
  assign out1_oe = ~io1_pair_sel & ~st.switch_enables[PCE_BIT_OUT1];
  assign out2_oe = io1_pair_sel ? ~out1_i : ~st.switch_enables[PCE_BIT_OUT2];

  // reset mode: out3 is released and feeds the converter warm reset
  assign out3_oe = ~conv_warm_reset_pin_en & ~st.switch_enables[PCE_BIT_OUT3];
  assign conv_warm_reset_n = conv_warm_reset_pin_en ? out3_i : 1'b1;

endmodule

`default_nettype wire

// [sim/pce_regs_assertions.sv]
// checker for the control and enable register bank
// assumes it is bound to pce_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pce_regs_checker
  import pce_pkg::*;
(
  // clock, reset, register port
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire pce_req_t   req,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  // power state
  input wire pce_seq_t   seq,
  input wire logic       freshness_seal_state,
  input wire logic       power_fail_comparator_out_n,
  input wire logic       power_fail_shutdown,
  input wire logic       backup_cell_measure_start,
  input wire pce_rails_t rails,
  // pins
  input wire logic       conv_warm_reset_pin_en,
  input wire logic       io1_pair_sel,
  input wire logic       out1_i,
  input wire logic       out1_oe,
  input wire logic       out2_oe,
  input wire logic       out3_i,
  input wire logic       out3_oe,
  input wire logic       conv_warm_reset_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_key_rd;
    req.rd && req.addr == PCE_ADDR_UNLOCK_KEY |=> rvalid && rdata == 8'h00;
  endproperty
  a_key_rd: assert property (p_key_rd) else $error("key readback not zero");
  property p_trig;
    req.wr && req.addr == PCE_ADDR_POWER_CONTROL && req.wdata[0] |=> backup_cell_measure_start;
  endproperty
  a_trig: assert property (p_trig) else $error("measure not started");
  property p_trig_cause;
    backup_cell_measure_start |-> $past(req.wr && req.addr == PCE_ADDR_POWER_CONTROL && req.wdata[0]);
  endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("measure start without write");
  property p_shut_rails;
    power_fail_shutdown |-> rails == '0 && $past(!power_fail_comparator_out_n);
  endproperty
  a_shut_rails: assert property (p_shut_rails) else $error("shutdown wrong");
  property p_no_trip;
    power_fail_comparator_out_n |=> !power_fail_shutdown;
  endproperty
  a_no_trip: assert property (p_no_trip) else $error("shutdown without trip");
  property p_out3;
    conv_warm_reset_pin_en |-> !out3_oe && conv_warm_reset_n == out3_i;
  endproperty
  a_out3: assert property (p_out3) else $error("out3 not a reset input");
  property p_pair;
    io1_pair_sel |-> !out1_oe && out2_oe == !out1_i;
  endproperty
  a_pair: assert property (p_pair) else $error("pairing wrong");
  property p_conv6;
    freshness_seal_state && rails.backup_conv6_on && power_fail_comparator_out_n |=> rails.backup_conv6_on;
  endproperty
  a_conv6: assert property (p_conv6) else $error("sealed backup rail dropped");
  property p_seq;
    seq.load && power_fail_comparator_out_n |=> rails.conv1_on == $past(seq.conv1_on) && rails.switch1_on == $past(seq.switch1_on);
  endproperty
  a_seq: assert property (p_seq) else $error("sequencer load lost");
endmodule
bind pce_regs pce_regs_checker pce_regs_checker_inst (.core_clk, .rstn, .req, .rdata, .rvalid, .seq,
  .freshness_seal_state, .power_fail_comparator_out_n, .power_fail_shutdown, .backup_cell_measure_start,
  .rails, .conv_warm_reset_pin_en, .io1_pair_sel, .out1_i, .out1_oe, .out2_oe, .out3_i, .out3_oe,
  .conv_warm_reset_n);
`default_nettype wire

// [sim/pce_host.sv]
// host model issuing register strobes to the bank
// assumes strobes sampled on rising core_clk, driven at falling edge
`timescale 1ns/1ps
`default_nettype none
module pce_host
  import pce_pkg::*;
(
  // clock
  input wire logic       core_clk,
  // register port
  output pce_req_t       req,
  input wire logic [7:0] rdata,
  input wire logic       rvalid
);
  initial req = '0;
  // idle bus shows inverted values so nothing stale can match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk) req <= '{1'b1, 1'b0, a, d};
    @(negedge core_clk) req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic uw(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
    wr(PCE_ADDR_UNLOCK_KEY, k);
    wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge core_clk) req <= '{1'b0, 1'b1, a, ~a};
    @(negedge core_clk) req <= '{1'b0, 1'b0, ~a, a};
    ok = rvalid;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// [sim/test_pce_regs.sv]
// self-checking bench for the control and enable register bank
// assumes the host model drives requests at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module test_pce_regs;
  import pce_pkg::*;
  localparam logic [7:0] KEY = 8'ha5; // arbitrary key value
  localparam logic [7:0] CT = PCE_ADDR_POWER_CONTROL;
  localparam logic [7:0] CV = PCE_ADDR_CONV_ENABLES;
  localparam logic [7:0] SW = PCE_ADDR_SWITCH_ENABLES;
  logic core_clk = 0, rstn = 0, wake_from_suspend = 0, wake_from_off = 0, freshness_seal_state = 0;
  logic power_fail_comparator_out_n = 1, conv_warm_reset_pin_en = 0, io1_pair_sel = 0, out1_i = 1, out3_i = 1;
  logic rvalid, power_fail_shutdown, backup_cell_measure_start, conv_warm_reset_n;
  logic out1_o, out1_oe, out2_o, out2_oe, out3_o, out3_oe;
  logic [7:0] rdata;
  pce_req_t req;
  pce_seq_t seq = '0;
  pce_rails_t rails;
  int err_total = 0;
  int checks_done = 0;
  always #5 core_clk = ~core_clk;
  pce_regs #(.UNLOCK_KEY(KEY)) pce_regs_inst (.*);
  pce_host pce_host_inst (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    pce_host_inst.rd(a, d, ok);
    chk({7'h0, ok}, 8'h01);
    chk(d, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic s_reset;
    rchk(CT, 8'h00);
    rchk(PCE_ADDR_RETENTION_FLAGS, 8'h00);
    rchk(CV, 8'h00);
    rchk(SW, 8'h00);
    rchk(8'h20, 8'h00);
  endtask
  task automatic s_ctrl;
    pce_host_inst.wr(CT, 8'hfe);
    chk({7'h0, backup_cell_measure_start}, 8'h00);
    pce_host_inst.wr(CT, 8'hff);
    chk({7'h0, backup_cell_measure_start}, 8'h01);
    rchk(CT, 8'h02);
  endtask
  task automatic s_lock;
    pce_host_inst.wr(CV, 8'h3f);
    rchk(CV, 8'h00);
    pce_host_inst.uw(KEY, CV, 8'hff);
    rchk(CV, 8'h3f);
    rchk(PCE_ADDR_UNLOCK_KEY, 8'h00);
    pce_host_inst.uw(KEY, SW, 8'hff);
    rchk(SW, 8'h7f);
    chk(rails[7:0], 8'hff);
    chk({5'h0, out1_oe, out2_oe, out3_oe}, 8'h00);
    pce_host_inst.uw(KEY, CT, 8'h00);
    pce_host_inst.wr(CV, 8'h00);
    rchk(CV, 8'h3f);
  endtask
  task automatic s_seal;
    freshness_seal_state = 1;
    pce_host_inst.uw(KEY, CV, 8'h00);
    rchk(CV, 8'h30);
    freshness_seal_state = 0;
    pce_host_inst.uw(KEY, CV, 8'h05);
    rchk(CV, 8'h05);
  endtask
  task automatic s_flags;
    pce_host_inst.uw(KEY, SW, 8'h11);
    wake_from_suspend = 1;
    @(negedge core_clk) wake_from_suspend = 0;
    rchk(PCE_ADDR_RETENTION_FLAGS, 8'h35);
    wake_from_off = 1;
    @(negedge core_clk) wake_from_off = 0;
    rchk(PCE_ADDR_RETENTION_FLAGS, 8'h00);
  endtask
  task automatic s_pins;
    #1 chk({5'h0, out1_oe, out2_oe, out3_oe}, 8'h03);
    chk({5'h0, out1_o, out2_o, out3_o}, 8'h00);
    @(negedge core_clk) out3_i = 0;
    #1 chk({7'h0, conv_warm_reset_n}, 8'h01);
    @(negedge core_clk) {conv_warm_reset_pin_en, io1_pair_sel} = 2'h3;
    #1 chk({5'h0, out1_oe, out2_oe, out3_oe}, 8'h00);
    chk({7'h0, conv_warm_reset_n}, 8'h00);
    @(negedge core_clk) out1_i = 0;
    #1 chk({7'h0, out2_oe}, 8'h01);
    @(negedge core_clk) {conv_warm_reset_pin_en, io1_pair_sel, out1_i, out3_i} = 4'h3;
  endtask
  task automatic s_seq;
    @(negedge core_clk) seq = 8'hff;
    @(negedge core_clk) seq = '0;
    rchk(CV, 8'h1f);
    rchk(SW, 8'h13);
  endtask
  task automatic s_pfail;
    power_fail_comparator_out_n = 0;
    @(negedge core_clk) power_fail_comparator_out_n = 1;
    chk({7'h0, power_fail_shutdown}, 8'h00);
    pce_host_inst.wr(CT, 8'h02);
    power_fail_comparator_out_n = 0;
    @(negedge core_clk) power_fail_comparator_out_n = 1;
    chk({7'h0, power_fail_shutdown}, 8'h01);
    chk(rails[7:0], 8'h00);
    rchk(CV, 8'h00);
  endtask
  // watchdog: a hung run still reaches the verdict
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (4) @(negedge core_clk);
    rstn = 1;
    s_reset;
    s_ctrl;
    s_lock;
    s_seal;
    s_flags;
    s_pins;
    s_seq;
    s_pfail;
    give_verdict;
  end
endmodule
`default_nettype wire
